// [core/vic_arbiter.sv]
// Level-then-order arbiter over the eligible sources.
// Assumes eligibility already holds gating, masking and the in-service level.
module vic_arbiter #(
    parameter int N = 21
) (
    // Per-source inputs
    input  wire logic [N-1:0]        elig,
    input  wire logic [N-1:0]        level,
    // Winner
    output vic_pkg::vic_grant_t      grant
);

    logic [N-1:0] high_req;
    logic [N-1:0] pick;
    logic [N-1:0] below;

    // High level first, then lowest order; scanning downward leaves the lowest.
    // Checks share this process so they never see a half-updated winner.
    always_comb begin
        high_req    = elig & level;
        pick        = (|high_req) ? high_req : elig;
        grant       = '0;
        grant.level = |high_req;
        for (int i = N - 1; i >= 0; i--) begin
            if (pick[i]) begin
                grant.valid = 1'b1;
                grant.order = i[vic_pkg::ORDER_W-1:0];
            end
        end
        below = (N'(1) << grant.order) - N'(1);
        if (grant.valid) begin
            a_same_level_lower: assert ((pick & below) == '0)
                else $error("lower order of the same level was passed over");
            a_high_beats_low: assert (grant.level || high_req == '0)
                else $error("low level granted while a high level waits");
        end
    end

endmodule : vic_arbiter

// [core/vic_pkg.sv]
// Shared constants, carriers and helpers of the vectored interrupt controller.
// Assumes one system clock; all special-register traffic arrives on that clock.
package vic_pkg;

    // Source count, fixed orders 0..20
    localparam int          NUM_SRC          = 21;
    localparam int          ORDER_W          = 5;

    // Special register addresses, valid in every register page
    localparam logic [7:0]  ADDR_PRIM_MASK   = 8'hA8;
    localparam logic [7:0]  ADDR_PRIM_LEVEL  = 8'hB8;
    localparam logic [7:0]  ADDR_EXT_MASK_A  = 8'hE6;
    localparam logic [7:0]  ADDR_EXT_LEVEL_A = 8'hF6;
    localparam logic [7:0]  ADDR_EXT_MASK_B  = 8'hE7;
    localparam logic [7:0]  ADDR_EXT_LEVEL_B = 8'hF7;

    // Primary mask register fields
    localparam int          GLOBAL_GATE_BIT  = 7;
    localparam int          SERIAL_PERIPH_BIT = 6;
    localparam int          TIMER_TWO_BIT    = 5;
    localparam int          SERIAL_PORT_A_BIT = 4;
    localparam int          TIMER_ONE_BIT    = 3;
    localparam int          EXT_LINE_B_BIT   = 2;
    localparam int          TIMER_ZERO_BIT   = 1;
    localparam int          EXT_LINE_A_BIT   = 0;

    // Reset values and writable-bit masks
    localparam logic [7:0]  PRIM_MASK_RST    = 8'h00;
    localparam logic [7:0]  PRIM_LEVEL_RST   = 8'h80;
    localparam logic [7:0]  EXT_A_RST        = 8'h00;
    localparam logic [7:0]  EXT_B_RST        = 8'h00;
    localparam logic [7:0]  ALL_WMASK        = 8'hFF;
    localparam logic [7:0]  PRIM_LEVEL_WMASK = 8'h7F;
    localparam logic [7:0]  EXT_A_WMASK      = 8'hFD;
    localparam logic [7:0]  EXT_B_WMASK      = 8'h3B;

    // Fixed orders with special meaning
    localparam int          FIRST_EXT_ORDER  = 7;
    localparam int          RSV_ORDER_A      = 8;
    localparam int          LEVEL_ORDER      = 15;
    localparam int          RSV_ORDER_B      = 17;

    // Vector layout
    localparam logic [15:0] VEC_BASE         = 16'h0003;
    localparam logic [15:0] VEC_STEP         = 16'h0008;

    // Special register access, one request per cycle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       bit_set;
        logic       bit_clr;
        logic [2:0] bit_idx;
    } vic_sfr_req_t;

    // Pending flags of the sources behind the primary mask register
    typedef struct packed {
        logic ext_line_a;
        logic timer_zero_overflow_flag;
        logic ext_line_b;
        logic timer_one_overflow_flag;
        logic serial_port_a_rx_flag;
        logic serial_port_a_tx_flag;
        logic timer_two_high_overflow_flag;
        logic timer_two_low_overflow_flag;
        logic serial_periph_done_flag;
        logic serial_periph_write_collision;
        logic serial_periph_mode_fault;
        logic serial_periph_rx_overrun;
    } vic_flags_t;

    // Arbitration result
    typedef struct packed {
        logic               valid;
        logic               level;
        logic [ORDER_W-1:0] order;
    } vic_grant_t;

    // In-service state; nested means high running over a preempted low
    typedef enum logic [1:0] {
        SVC_IDLE   = 2'b00,
        SVC_LOW    = 2'b01,
        SVC_HIGH   = 2'b10,
        SVC_NESTED = 2'b11
    } vic_svc_t;

    // Vector address of a fixed order
    function automatic logic [15:0] vector_of(input logic [ORDER_W-1:0] order);
        return VEC_BASE + VEC_STEP * {11'h000, order};
    endfunction : vector_of

    // Byte write or single-bit set/clear of one register
    function automatic logic [7:0] sfr_update(input logic [7:0]   old,
                                              input vic_sfr_req_t req,
                                              input logic [7:0]   addr,
                                              input logic [7:0]   wmask);
        logic [7:0] v;
        v = old;
        if (req.addr == addr) begin
            if (req.wr) begin
                v = req.wdata;
            end else if (req.bit_set) begin
                v[req.bit_idx] = 1'b1;
            end else if (req.bit_clr) begin
                v[req.bit_idx] = 1'b0;
            end
        end
        return (v & wmask) | (old & ~wmask);
    endfunction : sfr_update

endpackage : vic_pkg

// [core/vic_top.sv]
// Vectored interrupt controller: mask and level registers, source
// collection, arbitration, in-service tracking and the CPU request port.
// Assumes peripheral flags come from logic on clk; ext_line_c is a raw pin.
module vic_top (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   srst,
    // Special register access
    input  wire vic_pkg::vic_sfr_req_t  sfr_req,
    output logic [7:0]                  sfr_rdata,
    // Interrupt sources
    input  wire vic_pkg::vic_flags_t    flags,
    input  wire logic [20:7]            other_pending,
    input  wire logic                   ext_line_c,
    // CPU side
    output logic                        irq_req,
    output logic [15:0]                 irq_vector,
    output logic                        irq_level,
    input  wire logic                   cpu_ack,
    input  wire logic                   cpu_reti
);

    localparam int N = vic_pkg::NUM_SRC;

    logic [7:0]          prim_mask_reg;
    logic [7:0]          prim_level_reg;
    logic [7:0]          ext_mask_a_reg;
    logic [7:0]          ext_level_a_reg;
    logic [7:0]          ext_mask_b_reg;
    logic [7:0]          ext_level_b_reg;
    logic [7:0]          rdata_reg;
    logic                line_c_meta_reg;
    logic                line_c_reg;
    logic [N-1:0]        pend;
    logic [N-1:0]        en_vec;
    logic [N-1:0]        lvl_vec;
    logic [N-1:0]        elig;
    logic                global_irq_gate;
    vic_pkg::vic_svc_t   svc_reg;
    vic_pkg::vic_svc_t   svc_next;
    vic_pkg::vic_grant_t grant;
    logic                req_reg;
    logic [4:0]          order_reg;
    logic                level_reg;
    logic [15:0]         vec_reg;

    // Register writes; reserved bits hold their reset value
    always_ff @(posedge clk) begin
        if (srst) begin
            prim_mask_reg   <= vic_pkg::PRIM_MASK_RST;
            prim_level_reg  <= vic_pkg::PRIM_LEVEL_RST;
            ext_mask_a_reg  <= vic_pkg::EXT_A_RST;
            ext_level_a_reg <= vic_pkg::EXT_A_RST;
            ext_mask_b_reg  <= vic_pkg::EXT_B_RST;
            ext_level_b_reg <= vic_pkg::EXT_B_RST;
        end else begin
            prim_mask_reg   <= vic_pkg::sfr_update(prim_mask_reg, sfr_req,
                                   vic_pkg::ADDR_PRIM_MASK, vic_pkg::ALL_WMASK);
            prim_level_reg  <= vic_pkg::sfr_update(prim_level_reg, sfr_req,
                                   vic_pkg::ADDR_PRIM_LEVEL, vic_pkg::PRIM_LEVEL_WMASK);
            ext_mask_a_reg  <= vic_pkg::sfr_update(ext_mask_a_reg, sfr_req,
                                   vic_pkg::ADDR_EXT_MASK_A, vic_pkg::EXT_A_WMASK);
            ext_level_a_reg <= vic_pkg::sfr_update(ext_level_a_reg, sfr_req,
                                   vic_pkg::ADDR_EXT_LEVEL_A, vic_pkg::EXT_A_WMASK);
            ext_mask_b_reg  <= vic_pkg::sfr_update(ext_mask_b_reg, sfr_req,
                                   vic_pkg::ADDR_EXT_MASK_B, vic_pkg::EXT_B_WMASK);
            ext_level_b_reg <= vic_pkg::sfr_update(ext_level_b_reg, sfr_req,
                                   vic_pkg::ADDR_EXT_LEVEL_B, vic_pkg::EXT_B_WMASK);
        end
    end

    // Register reads, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= 8'h00;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                vic_pkg::ADDR_PRIM_MASK:   rdata_reg <= prim_mask_reg;
                vic_pkg::ADDR_PRIM_LEVEL:  rdata_reg <= prim_level_reg;
                vic_pkg::ADDR_EXT_MASK_A:  rdata_reg <= ext_mask_a_reg;
                vic_pkg::ADDR_EXT_LEVEL_A: rdata_reg <= ext_level_a_reg;
                vic_pkg::ADDR_EXT_MASK_B:  rdata_reg <= ext_mask_b_reg;
                vic_pkg::ADDR_EXT_LEVEL_B: rdata_reg <= ext_level_b_reg;
                default:                   rdata_reg <= 8'h00;
            endcase
        end
    end
    assign sfr_rdata = rdata_reg;

    // Level line C comes off a pin; second flop alone feeds logic
    always_ff @(posedge clk) begin
        if (srst) begin
            line_c_meta_reg <= 1'b0;
            line_c_reg      <= 1'b0;
        end else begin
            line_c_meta_reg <= ext_line_c;
            line_c_reg      <= line_c_meta_reg;
        end
    end

    // Pending vector by fixed order, independent of any enable
    always_comb begin
        pend = '0;
        pend[vic_pkg::EXT_LINE_A_BIT]    = flags.ext_line_a;
        pend[vic_pkg::TIMER_ZERO_BIT]    = flags.timer_zero_overflow_flag;
        pend[vic_pkg::EXT_LINE_B_BIT]    = flags.ext_line_b;
        pend[vic_pkg::TIMER_ONE_BIT]     = flags.timer_one_overflow_flag;
        pend[vic_pkg::SERIAL_PORT_A_BIT] = flags.serial_port_a_rx_flag
                                         | flags.serial_port_a_tx_flag;
        pend[vic_pkg::TIMER_TWO_BIT]     = flags.timer_two_high_overflow_flag
                                         | flags.timer_two_low_overflow_flag;
        pend[vic_pkg::SERIAL_PERIPH_BIT] = flags.serial_periph_done_flag
                                         | flags.serial_periph_write_collision
                                         | flags.serial_periph_mode_fault
                                         | flags.serial_periph_rx_overrun;
        pend[N-1:vic_pkg::FIRST_EXT_ORDER] = other_pending;
        pend[vic_pkg::LEVEL_ORDER]       = line_c_reg;     // No flag; live level
        pend[vic_pkg::RSV_ORDER_A]       = 1'b0;
        pend[vic_pkg::RSV_ORDER_B]       = 1'b0;
    end

    // Enable and level per order; primary bit n is order n, extended A bit n is order 7+n, extended B bit n is order 15+n
    assign en_vec          = {ext_mask_b_reg[5:0], ext_mask_a_reg, prim_mask_reg[6:0]};
    assign lvl_vec         = {ext_level_b_reg[5:0], ext_level_a_reg, prim_level_reg[6:0]};
    assign global_irq_gate = prim_mask_reg[vic_pkg::GLOBAL_GATE_BIT];

    // Eligibility: gate, enable, and room under the running service level
    always_comb begin
        for (int i = 0; i < N; i++) begin
            elig[i] = global_irq_gate && en_vec[i] && pend[i];
            if (svc_reg == vic_pkg::SVC_HIGH || svc_reg == vic_pkg::SVC_NESTED) begin
                elig[i] = 1'b0;
            end else if (svc_reg == vic_pkg::SVC_LOW && !lvl_vec[i]) begin
                elig[i] = 1'b0;
            end
        end
    end

    vic_arbiter #(
        .N     (N)
    ) u_arbiter (
        .elig  (elig),
        .level (lvl_vec),
        .grant (grant)
    );

    // Request latch; held until acknowledged, reloaded from the current winner if its source loses eligibility
    always_ff @(posedge clk) begin
        if (srst) begin
            req_reg   <= 1'b0;
            order_reg <= 5'h00;
            level_reg <= 1'b0;
            vec_reg   <= vic_pkg::VEC_BASE;
        end else if (req_reg && cpu_ack) begin
            req_reg   <= 1'b0;   // Service state moves this edge; re-decide after
        end else if (req_reg && elig[order_reg]) begin
            req_reg   <= 1'b1;
        end else begin
            req_reg   <= grant.valid;
            order_reg <= grant.order;
            level_reg <= grant.level;
            vec_reg   <= vic_pkg::vector_of(grant.order);
        end
    end
    assign irq_req    = req_reg;
    assign irq_vector = vec_reg;
    assign irq_level  = level_reg;

    // In-service tracking; a return closes the innermost level
    always_comb begin
        svc_next = svc_reg;
        if (req_reg && cpu_ack) begin
            case (svc_reg)
                vic_pkg::SVC_IDLE: svc_next = level_reg ? vic_pkg::SVC_HIGH : vic_pkg::SVC_LOW;
                vic_pkg::SVC_LOW:  svc_next = vic_pkg::SVC_NESTED;
                default:           svc_next = svc_reg;
            endcase
        end else if (cpu_reti) begin
            case (svc_reg)
                vic_pkg::SVC_NESTED: svc_next = vic_pkg::SVC_LOW;
                vic_pkg::SVC_HIGH:   svc_next = vic_pkg::SVC_IDLE;
                vic_pkg::SVC_LOW:    svc_next = vic_pkg::SVC_IDLE;
                default:             svc_next = vic_pkg::SVC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            svc_reg <= vic_pkg::SVC_IDLE;
        end else begin
            svc_reg <= svc_next;
        end
    end

    // Checks
    a_gate_off_quiet: assert property (@(posedge clk) disable iff (srst)
        !global_irq_gate |=> !irq_req)
        else $error("request raised with the global gate off");
    a_enable_needed: assert property (@(posedge clk) disable iff (srst)
        $rose(irq_req)
        |-> $past(global_irq_gate && en_vec[grant.order] && pend[grant.order]))
        else $error("request raised with no enabled pending source");
    a_vector_map: assert property (@(posedge clk) disable iff (srst)
        irq_req |-> irq_vector == 16'h0003 + 16'h0008 * {11'h000, order_reg})
        else $error("vector does not match the granted order");
    a_detect_cycle: assert property (@(posedge clk) disable iff (srst)
        !irq_req && grant.valid |=> irq_req)
        else $error("eligible source not requested after one cycle");
    a_req_holds: assert property (@(posedge clk) disable iff (srst)
        irq_req && !cpu_ack && elig[order_reg] |=> irq_req && $stable(irq_vector))
        else $error("request or vector changed before acknowledge");
    a_ack_drops: assert property (@(posedge clk) disable iff (srst)
        irq_req && cpu_ack |=> !irq_req)
        else $error("request still raised after acknowledge");
    a_high_unbroken: assert property (@(posedge clk) disable iff (srst)
        (svc_reg == vic_pkg::SVC_HIGH || svc_reg == vic_pkg::SVC_NESTED) |-> !irq_req)
        else $error("request raised during high-level service");
    a_low_preempt: assert property (@(posedge clk) disable iff (srst)
        svc_reg == vic_pkg::SVC_LOW && irq_req |-> irq_level)
        else $error("low request raised during low-level service");
    a_bit_set_mask: assert property (@(posedge clk) disable iff (srst)
        sfr_req.bit_set && !sfr_req.wr && sfr_req.addr == vic_pkg::ADDR_PRIM_MASK
        |=> prim_mask_reg[$past(sfr_req.bit_idx)])
        else $error("bit set on the primary mask register lost");
    a_reserved_quiet: assert property (@(posedge clk) disable iff (srst)
        irq_req |-> order_reg != 5'd8 && order_reg != 5'd17)
        else $error("reserved vector requested");

    // Service time of the partner runs past thirty cycles
    c_plain_service: cover property (@(posedge clk) disable iff (srst)
        irq_req ##1 cpu_ack ##[1:40] cpu_reti);
    c_nested: cover property (@(posedge clk) disable iff (srst)
        svc_reg == vic_pkg::SVC_NESTED);
    c_drop_on_gate: cover property (@(posedge clk) disable iff (srst)
        irq_req ##1 !irq_req && !$past(cpu_ack));

endmodule : vic_top

// [dv/vic_cpu_model.sv]
// Behavioural CPU core that takes vectored requests and returns from service.
// Assumes requests come from vic_top on clk; drives its outputs at the falling edge.
module vic_cpu_model #(
    parameter int ACK_DLY = 2,
    parameter int SVC_DLY = 30
) (
    // Clock, reset and enable
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        en,
    // Request from the controller
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic        irq_level,
    // Answers to the controller
    output logic             cpu_ack,
    output logic             cpu_reti,
    // Record of the last vector taken
    output logic [15:0]      took_vec,
    output logic             took_lvl,
    output int               takes
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_c;
    int svc_c;
    int depth;

    initial begin
        cpu_ack = 1'b0;
        cpu_reti = 1'b0;
        took_vec = 16'h0000;
        took_lvl = 1'b0;
        takes = 0;
    end

    // Ack after a delay; a fixed service time per nesting level, then return
    always @(negedge clk) begin
        cpu_ack <= 1'b0;
        cpu_reti <= 1'b0;
        if (srst) begin
            wait_c <= 0;
            svc_c <= 0;
            depth <= 0;
        end else if (en && irq_req && !cpu_ack) begin
            wait_c <= wait_c + 1;
            if (wait_c == ACK_DLY) begin
                cpu_ack <= 1'b1;
                took_vec <= irq_vector;
                took_lvl <= irq_level;
                takes <= takes + 1;
                depth <= depth + 1;
                svc_c <= 0;
                wait_c <= 0;
            end
        end else if (depth > 0) begin
            wait_c <= 0;
            svc_c <= (svc_c == SVC_DLY) ? 0 : svc_c + 1;
            if (svc_c == SVC_DLY) begin
                cpu_reti <= 1'b1;
                depth <= depth - 1;
            end
        end
    end
endmodule : vic_cpu_model

// [dv/vic_top_tb.sv]
// Self-checking bench of vic_top with a CPU model at its request port.
// Assumes one 125 MHz clock; inputs change at the falling edge.
module vic_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk, srst, cpu_en, cpu_ack, cpu_reti, ext_line_c;
    logic                  irq_req, irq_level, took_lvl;
    vic_pkg::vic_sfr_req_t sfr_req;
    vic_pkg::vic_flags_t   flags;
    logic [20:7]           other_pending;
    logic [7:0]            sfr_rdata, m, lv;
    logic [15:0]           irq_vector, took_vec;
    logic [6:0]            exp;
    int                    takes, miscompares, checked, cycles;

    vic_top dut (.clk(clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .flags(flags), .other_pending(other_pending), .ext_line_c(ext_line_c),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
        .cpu_ack(cpu_ack), .cpu_reti(cpu_reti));
    vic_cpu_model cpu (.clk(clk), .srst(srst), .en(cpu_en), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_level(irq_level), .cpu_ack(cpu_ack),
        .cpu_reti(cpu_reti), .took_vec(took_vec), .took_lvl(took_lvl), .takes(takes));

    // Expected winner among the primary sources: {valid, level, order}
    function automatic logic [6:0] pick(input vic_pkg::vic_flags_t f,
                                        input logic [7:0] msk, input logic [7:0] lvl);
        logic [6:0] p;
        logic [6:0] e;
        logic [6:0] r;
        p = {f.serial_periph_done_flag | f.serial_periph_write_collision |
             f.serial_periph_mode_fault | f.serial_periph_rx_overrun,
             f.timer_two_high_overflow_flag | f.timer_two_low_overflow_flag,
             f.serial_port_a_rx_flag | f.serial_port_a_tx_flag, f.timer_one_overflow_flag,
             f.ext_line_b, f.timer_zero_overflow_flag, f.ext_line_a};
        e = p & msk[6:0] & {7{msk[7]}};
        r = 7'h00;
        for (int i = 6; i >= 0; i--) if (e[i] && !lvl[i]) r = {2'b10, 5'(i)};
        for (int i = 6; i >= 0; i--) if (e[i] && lvl[i]) r = {2'b11, 5'(i)};
        return r;
    endfunction : pick

    function automatic logic [15:0] vec(input logic [4:0] order);
        return 16'h0003 + 16'h0008 * {11'h000, order};
    endfunction : vec

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk

    // One register access; op is {wr, rd, bit_set, bit_clr}
    task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] op,
                       input logic [2:0] b);
        @(negedge clk);
        sfr_req <= {a, d, op, b};
        @(negedge clk);
        sfr_req <= '0;
    endtask : sfr

    // Bounded wait for the CPU model to take its n-th vector
    task automatic wait_take(input int n);
        for (int k = 0; k < 200 && takes != n; k++) @(negedge clk);
        chk(16'(takes), 16'(n));
    endtask : wait_take

    task automatic conclude();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard, well above the fewer than eight hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        srst = 1'b1;
        sfr_req = '0;
        flags = '0;
        other_pending = '0;
        ext_line_c = 1'b0;
        cpu_en = 1'b0;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        m = 8'($urandom(38523));
        repeat (6) @(negedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(irq_req, 1'b0);
        chk(irq_vector, 16'h0003);
        sfr(8'hA8, 8'h00, 4'b0100, 3'h0);
        chk(sfr_rdata, 8'h00);
        sfr(8'hB8, 8'h00, 4'b0100, 3'h0);
        chk(sfr_rdata, 8'h80);
        sfr(8'h55, 8'h00, 4'b0100, 3'h0);
        chk(sfr_rdata, 8'h00);
        $display("test reset done");
        // Random masks, levels and flags; first two pass with gate off and all on.
        // Gate drops first: a request still held from the last pass would hide the winner.
        for (int n = 0; n < 60; n++) begin
            m = (n == 0) ? 8'h7F : (n == 1) ? 8'hFF : 8'($urandom);
            lv = 8'($urandom);
            sfr(8'hA8, 8'h00, 4'b1000, 3'h0);
            sfr(8'hB8, lv, 4'b1000, 3'h0);
            sfr(8'hB8, 8'h00, 4'b0100, 3'h0);
            chk(sfr_rdata, lv | 8'h80);
            flags <= 12'($urandom & $urandom);
            other_pending <= 14'($urandom);
            ext_line_c <= 1'($urandom);
            sfr(8'hA8, m, 4'b1000, 3'h0);
            repeat (2) @(negedge clk);
            exp = pick(flags, m, lv);
            chk(irq_req, exp[6]);
            if (exp[6]) begin
                chk(irq_vector, vec(exp[4:0]));
                chk(irq_level, exp[5]);
            end
        end
        $display("test arbitration done");
        // Reserved order 8 never requests; orders 7 and 20 at both ends
        flags <= '0;
        other_pending <= 14'h0002;
        ext_line_c <= 1'b0;
        sfr(8'hE6, 8'hFF, 4'b1000, 3'h0);
        sfr(8'hE7, 8'hFF, 4'b1000, 3'h0);
        sfr(8'hA8, 8'h80, 4'b1000, 3'h0);
        sfr(8'hE6, 8'h00, 4'b0100, 3'h0);
        chk(sfr_rdata, 8'hFD);
        chk(irq_req, 1'b0);
        other_pending <= 14'h2003;
        repeat (2) @(negedge clk);
        chk(irq_vector, 16'h003B);
        // Held request would keep its vector; drop it by the gate, then raise both at once
        sfr(8'hA8, 8'h00, 4'b0001, 3'h7);
        sfr(8'hF7, 8'h00, 4'b0010, 3'h5);
        chk(irq_req, 1'b0);
        sfr(8'hA8, 8'h00, 4'b0010, 3'h7);
        @(negedge clk);
        chk(irq_vector, 16'h00A3);
        other_pending <= '0;
        sfr(8'hE6, 8'h00, 4'b1000, 3'h0);
        sfr(8'hE7, 8'h00, 4'b1000, 3'h0);
        $display("test extended done");
        // Pending while disabled, then service, preemption and no preemption of high
        sfr(8'hB8, 8'h80, 4'b1000, 3'h0);
        flags.timer_zero_overflow_flag <= 1'b1;
        @(negedge clk);
        chk(irq_req, 1'b0);
        sfr(8'hA8, 8'h00, 4'b0010, 3'h1);
        @(negedge clk);
        chk(irq_req, 1'b1);
        cpu_en <= 1'b1;
        wait_take(1);
        chk(took_vec, 16'h000B);
        flags.timer_zero_overflow_flag <= 1'b0;
        sfr(8'hB8, 8'h81, 4'b1000, 3'h0);
        flags.ext_line_a <= 1'b1;
        sfr(8'hA8, 8'h00, 4'b0010, 3'h0);
        wait_take(2);
        chk(took_vec, 16'h0003);
        chk(took_lvl, 1'b1);
        flags.ext_line_a <= 1'b0;
        sfr(8'hB8, 8'h00, 4'b0010, 3'h3);
        flags.timer_one_overflow_flag <= 1'b1;
        sfr(8'hA8, 8'h00, 4'b0010, 3'h3);
        @(negedge clk);
        chk(irq_req, 1'b0);
        wait_take(3);
        chk(took_vec, 16'h001B);
        flags.timer_one_overflow_flag <= 1'b0;
        $display("test service done");
        repeat (80) @(negedge clk);
        conclude();
    end
endmodule : vic_top_tb
